/* File: node_cfg_block.sv */
/*
 * Node setup and pin status registers with reply gap timing and chain address output.
 * Assumes a serial front end on i_ref_clk that issues register reads, writes,
 * reply requests and bit-time ticks; pin and analog levels arrive asynchronously.
 */
`include "node_cfg_regs.svh"

// Overview of operation
// - reply waits eight bit times times chosen multiple
// - eight-bit node slot, reset zero, sets address
// - pins CSN SCK SDI add zero to seven
// - status word returns sampled input pin levels
// - fixed eight-bit chip version in top byte
// - three-bit die revision, fixed by parameter, defaults to zero
// - bit fifteen flags converter not working
// - bit fourteen shows external oscillator in use
// - bit thirteen shows reference resistor detected
// - bit twelve sets next address output polarity
// - polarity bit resets to one
// - bit six shows serial interface selected
// - bits eleven to eight show comparator outputs
module node_cfg_block #(
	parameter logic [7:0] CHIP_VERSION = 8'h5a, // arbitrary value
	parameter logic [2:0] DIE_REVISION = 3'h0
) (
	input  wire logic               i_ref_clk,
	input  wire logic               i_srst,
	input  wire logic               i_clk_en,
	input  wire logic               i_reg_wr,
	input  wire logic               i_reg_rd,
	input  wire logic [6:0]         i_reg_addr,
	input  wire node_cfg_pkg::word_t i_reg_wdata,
	output node_cfg_pkg::word_t     o_reg_rdata,
	output logic                    o_reg_rvalid,
	input  wire logic               i_reply_req,
	input  wire logic               i_bit_tick,
	output logic                    o_reply_go,
	output node_cfg_pkg::slot_t     o_node_addr,
	input  wire logic               i_left_stop_pin,
	input  wire logic               i_right_stop_pin,
	input  wire logic               i_encoder_b_pin,
	input  wire logic               i_encoder_a_pin,
	input  wire logic               i_bridge_off_pin,
	input  wire logic               i_encoder_index_pin,
	input  wire logic               i_one_wire_serial,
	input  wire logic               i_csn_pin,
	input  wire logic               i_sck_pin,
	input  wire logic               i_sdi_pin,
	input  wire logic [3:0]         i_cmp_levels,
	input  wire logic               i_conv_fault,
	input  wire logic               i_outside_osc_selected,
	input  wire logic               i_ref_resistor_found,
	output logic                    o_next_addr_out,
	output logic                    o_next_addr_oe_n
);
	import node_cfg_pkg::*;

	localparam int NSYNC = 17;

	logic [NSYNC-1:0] raw_pins;
	logic [NSYNC-1:0] pins_s;
	slot_t            slot_q;
	gap_code_t        gap_code_q;
	logic             polarity_q;
	word_t            rdata_q;
	logic             rvalid_q;
	slot_t            node_addr_q;
	logic             next_addr_q;
	logic             next_addr_oe_n_q;
	logic             reply_go_q;
	logic [6:0]       pin_bits;
	logic [2:0]       strap_off;
	slot_t            addr_sum;
	word_t            setup_word;
	word_t            status_word;
	logic             wr_setup;
	logic             wr_status;

	reply_gap_if gap ();

	assign raw_pins = {i_ref_resistor_found, i_outside_osc_selected, i_conv_fault,
	                   i_cmp_levels, i_csn_pin, i_sck_pin, i_sdi_pin,
	                   i_one_wire_serial, i_encoder_index_pin, i_bridge_off_pin,
	                   i_encoder_a_pin, i_encoder_b_pin, i_right_stop_pin,
	                   i_left_stop_pin};

	pin_sync #(
		.W (NSYNC)
	) u_pin_sync (
		.i_ref_clk (i_ref_clk),
		.i_srst    (i_srst),
		.i_clk_en  (i_clk_en),
		.i_async   (raw_pins),
		.o_sync    (pins_s)
	);

	reply_gap_timer u_gap_timer (
		.i_ref_clk  (i_ref_clk),
		.i_srst     (i_srst),
		.i_clk_en   (i_clk_en),
		.i_bit_tick (i_bit_tick),
		.gap        (gap.timer)
	);

	assign pin_bits  = pins_s[6:0];
	assign strap_off = pins_s[9:7]; // csn is the most significant bit
	// wraps above 255; keeping the sum in range is the host's duty
	assign addr_sum  = slot_t'(slot_q + {5'h00, strap_off});

	assign wr_setup  = i_reg_wr && (i_reg_addr == `NODE_SETUP_IDX);
	assign wr_status = i_reg_wr && (i_reg_addr == `PIN_STATUS_IDX);

	always_comb begin
		setup_word = '0;
		setup_word[`GAP_MSB:`GAP_LSB]   = gap_code_q;
		setup_word[`SLOT_MSB:`SLOT_LSB] = slot_q;
	end

	always_comb begin
		status_word = '0; // reserved bits read zero
		status_word[`PIN_UART_SEL:`PIN_LEFT_STOP]  = pin_bits;
		status_word[`PIN_CMP_LSB+3:`PIN_CMP_LSB]   = pins_s[13:10];
		status_word[`PIN_POLARITY]                 = polarity_q;
		status_word[`PIN_RES_FOUND]                = pins_s[16];
		status_word[`PIN_OSC_EXT]                  = pins_s[15];
		status_word[`PIN_CONV_ERR]                 = pins_s[14];
		status_word[`PIN_REV_MSB:`PIN_REV_LSB]     = DIE_REVISION;
		status_word[`PIN_VER_MSB:`PIN_VER_LSB]     = CHIP_VERSION;
	end

	// node setup word
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			slot_q     <= slot_t'(`NODE_SETUP_RST);
			gap_code_q <= gap_code_t'(`NODE_SETUP_RST >> `GAP_LSB);
		end else if (i_clk_en && wr_setup) begin
			slot_q     <= i_reg_wdata[`SLOT_MSB:`SLOT_LSB];
			gap_code_q <= i_reg_wdata[`GAP_MSB:`GAP_LSB];
		end
	end

	// only the polarity bit of the status word is writable
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			polarity_q <= `POLARITY_RST;
		end else if (i_clk_en && wr_status) begin
			polarity_q <= i_reg_wdata[`PIN_POLARITY];
		end
	end

	// read port, unmapped indices answer zero
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			rdata_q  <= '0;
			rvalid_q <= 1'b0;
		end else if (i_clk_en) begin
			rvalid_q <= i_reg_rd;
			if (i_reg_rd) begin
				case (i_reg_addr)
					`NODE_SETUP_IDX: rdata_q <= setup_word;
					`PIN_STATUS_IDX: rdata_q <= status_word;
					default:         rdata_q <= '0;
				endcase
			end
		end
	end

	// effective address and chain output
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			node_addr_q      <= 8'h00;
			next_addr_q      <= `POLARITY_RST;
			next_addr_oe_n_q <= 1'b1;
		end else if (i_clk_en) begin
			node_addr_q      <= addr_sum;
			next_addr_q      <= polarity_q;
			next_addr_oe_n_q <= !pins_s[`PIN_UART_SEL];
		end
	end

	// reply requests while the timer runs are dropped
	assign gap.start = i_reply_req && !gap.busy;
	assign gap.code  = gap_code_q;

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			reply_go_q <= 1'b0;
		end else if (i_clk_en) begin
			reply_go_q <= gap.done;
		end
	end

	assign o_reg_rdata      = rdata_q;
	assign o_reg_rvalid     = rvalid_q;
	assign o_node_addr      = node_addr_q;
	assign o_next_addr_out  = next_addr_q;
	assign o_next_addr_oe_n = next_addr_oe_n_q;
	assign o_reply_go       = reply_go_q;

	sequence s_rd_status;
		i_clk_en && i_reg_rd && i_reg_addr == `PIN_STATUS_IDX;
	endsequence

	sequence s_rd_other;
		i_clk_en && i_reg_rd && i_reg_addr != `PIN_STATUS_IDX
			&& i_reg_addr != `NODE_SETUP_IDX;
	endsequence

	sequence s_rd_setup;
		i_clk_en && i_reg_rd && i_reg_addr == `NODE_SETUP_IDX;
	endsequence

	a_addr_offset: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		i_clk_en |=> o_node_addr == slot_t'($past(slot_q) + {5'h00, $past(pins_s[9:7])}))
		else $error("node address does not include the strap offset");

	a_pol_reset: assert property (@(posedge i_ref_clk)
		i_srst |=> polarity_q == 1'b1 && o_next_addr_oe_n)
		else $error("polarity bit not one after reset");

	a_status_write: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		i_clk_en && wr_status && !wr_setup |=> polarity_q == $past(i_reg_wdata[12])
			&& $stable(slot_q) && $stable(gap_code_q))
		else $error("status write touched more than the polarity bit");

	a_rd_version: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		s_rd_status |=> o_reg_rvalid && o_reg_rdata[31:24] == CHIP_VERSION
			&& o_reg_rdata[23:19] == 5'h00 && o_reg_rdata[7] == 1'b0)
		else $error("status read shows wrong version or nonzero reserved bits");

	a_rd_pins: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		s_rd_status |=> o_reg_rdata[6:0] == $past(pins_s[6:0])
			&& o_reg_rdata[15:8] == {$past(pins_s[14]), $past(pins_s[15]), $past(pins_s[16]),
			$past(polarity_q), $past(pins_s[13:10])})
		else $error("status read does not show sampled pins");

	a_rd_unmapped: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		s_rd_other |=> o_reg_rvalid && o_reg_rdata == 32'h0000_0000)
		else $error("unmapped read returned data");

	a_setup_write: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		i_clk_en && wr_setup ##1 i_clk_en && i_reg_rd && i_reg_addr == `NODE_SETUP_IDX
			|=> o_reg_rdata == {20'h00000, $past(i_reg_wdata[11:0], 2)})
		else $error("node setup word does not read back");

	a_next_addr_drive: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		i_clk_en |=> o_next_addr_oe_n == !$past(pins_s[6]) && o_next_addr_out == $past(polarity_q))
		else $error("chain output not driven from polarity in serial mode");

	a_reply_after: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		i_clk_en && gap.done |=> o_reply_go)
		else $error("reply release not forwarded");

	// checks on reset, hold, freeze, read-back, gap timer start and reply release pulse
	a_setup_reset: assert property (@(posedge i_ref_clk)
		i_srst |=> slot_q == 8'h00 && gap_code_q == 4'h0 && o_node_addr == 8'h00
			&& !o_reg_rvalid && !o_reply_go)
		else $error("node setup or outputs not cleared by reset");

	a_chain_reset: assert property (@(posedge i_ref_clk)
		i_srst |=> o_next_addr_out)
		else $error("chain output not one after reset");

	a_setup_hold: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		!(i_clk_en && wr_setup) |=> $stable(slot_q) && $stable(gap_code_q))
		else $error("node setup changed without an enabled write");

	a_pol_hold: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		!(i_clk_en && wr_status) |=> $stable(polarity_q))
		else $error("polarity bit changed without an enabled write");

	a_rd_setup: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		s_rd_setup |=> o_reg_rvalid
			&& o_reg_rdata == {20'h00000, $past(gap_code_q), $past(slot_q)})
		else $error("node setup read shows wrong fields");

	a_rd_revision: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		s_rd_status |=> o_reg_rdata[18:16] == DIE_REVISION)
		else $error("status read shows wrong die revision");

	a_rd_faults: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		s_rd_status |=> o_reg_rdata[15:13]
			== {$past(pins_s[14]), $past(pins_s[15]), $past(pins_s[16])})
		else $error("status read shows wrong fault or clock bits");

	a_rd_idle: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		i_clk_en && !i_reg_rd |=> !o_reg_rvalid && $stable(o_reg_rdata))
		else $error("read data moved or valid rose without a read");

	a_freeze_outputs: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		!i_clk_en |=> $stable(o_node_addr) && $stable(o_next_addr_out)
			&& $stable(o_reg_rdata) && $stable(o_reg_rvalid) && $stable(o_reply_go))
		else $error("outputs moved while the clock enable was low");

	a_gap_accept: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		i_clk_en && gap.start |=> gap.busy)
		else $error("accepted reply request did not start the gap timer");

	a_go_pulse: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		i_clk_en && o_reply_go |=> !o_reply_go)
		else $error("reply release stood longer than one cycle");

endmodule : node_cfg_block

/* File: node_cfg_regs.svh */
/*
 * Offsets, field positions and reset values of the node setup and pin status words.
 * Assumes it is included by bare name wherever these values are needed.
 */
`ifndef NODE_CFG_REGS_SVH
`define NODE_CFG_REGS_SVH

`define NODE_SETUP_IDX       7'h03
`define PIN_STATUS_IDX       7'h04
`define NODE_SETUP_RST       32'h0000_0000

`define SLOT_LSB             0
`define SLOT_MSB             7
`define GAP_LSB              8
`define GAP_MSB              11

`define PIN_LEFT_STOP        0
`define PIN_UART_SEL         6
`define PIN_CMP_LSB          8
`define PIN_POLARITY         12
`define PIN_RES_FOUND        13
`define PIN_OSC_EXT          14
`define PIN_CONV_ERR         15
`define PIN_REV_LSB          16
`define PIN_REV_MSB          18
`define PIN_VER_LSB          24
`define PIN_VER_MSB          31

`define POLARITY_RST         1'b1
`define GAP_UNIT_BITS        7'h08
`define GAP_SHORTEST_MULT    7'h01

`endif

/* File: node_cfg_pkg.sv */
/*
 * Types shared by the node setup and pin status block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package node_cfg_pkg;

	typedef logic [7:0]  slot_t;
	typedef logic [31:0] word_t;
	typedef logic [3:0]  gap_code_t;

	typedef enum logic [2:0] {
		GAP_IDLE = 3'b001,
		GAP_WAIT = 3'b010,
		GAP_DONE = 3'b100
	} gap_state_e;

endpackage : node_cfg_pkg

/* File: reply_gap_if.sv */
/*
 * Carrier between the register block and its reply gap timer.
 * Assumes both ends run on the same clock.
 */
interface reply_gap_if;
	import node_cfg_pkg::*;

	logic      start;
	gap_code_t code;
	logic      done;
	logic      busy;

	modport ctrl  (output start, output code, input done, input busy);
	modport timer (input start, input code, output done, output busy);

endinterface : reply_gap_if

/* File: pin_sync.sv */
/*
 * Two-stage synchroniser for a group of pin levels.
 * Assumes every input bit is asynchronous to i_ref_clk.
 */
module pin_sync #(
	parameter int W = 17
) (
	input  wire logic         i_ref_clk,
	input  wire logic         i_srst,
	input  wire logic         i_clk_en,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	for (genvar b = 0; b < W; b++) begin : g_bit
		always_ff @(posedge i_ref_clk) begin
			if (i_srst) begin
				meta_q[b] <= 1'b0;
				sync_q[b] <= 1'b0;
			end else if (i_clk_en) begin
				meta_q[b] <= i_async[b];
				sync_q[b] <= meta_q[b];
			end
		end
	end

	assign o_sync = sync_q;

endmodule : pin_sync

/* File: reply_gap_timer.sv */
/*
 * Counts bit times between a received request and the moment a reply may start.
 * Assumes i_bit_tick is a one-cycle pulse per serial bit time on the same clock.
 */
`include "node_cfg_regs.svh"

module reply_gap_timer (
	input  wire logic  i_ref_clk,
	input  wire logic  i_srst,
	input  wire logic  i_clk_en,
	input  wire logic  i_bit_tick,
	reply_gap_if.timer gap
);
	import node_cfg_pkg::*;

	gap_state_e state_q;
	logic [6:0] cnt_q;
	logic [6:0] target_q;
	logic       done_q;
	logic [6:0] mult;

	// even codes give code+1 units, odd codes fall back to the even code below
	always_comb begin
		mult = (gap.code[3:1] == 3'h0) ? `GAP_SHORTEST_MULT : {3'h0, gap.code[3:1], 1'b1};
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			state_q  <= GAP_IDLE;
			cnt_q    <= 7'h00;
			target_q <= 7'h00;
			done_q   <= 1'b0;
		end else if (i_clk_en) begin
			done_q <= 1'b0;
			case (state_q)
				GAP_IDLE: begin
					if (gap.start) begin
						target_q <= 7'(mult * `GAP_UNIT_BITS);
						cnt_q    <= 7'h00;
						state_q  <= GAP_WAIT;
					end
				end
				GAP_WAIT: begin
					if (i_bit_tick) begin
						if (cnt_q == 7'(target_q - 7'h01)) begin
							done_q  <= 1'b1;
							state_q <= GAP_DONE;
						end
						cnt_q <= 7'(cnt_q + 7'h01);
					end
				end
				GAP_DONE: state_q <= GAP_IDLE;
				default:  state_q <= GAP_IDLE;
			endcase
		end
	end

	assign gap.done = done_q;
	assign gap.busy = (state_q != GAP_IDLE);

	sequence s_gap_started;
		i_clk_en && state_q == GAP_IDLE && gap.start;
	endsequence

	a_gap_done_count: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		done_q |-> $past(cnt_q) == 7'(target_q - 7'h01) && $past(i_bit_tick))
		else $error("reply released before the full bit count");

	a_gap_shortest: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		s_gap_started ##0 (gap.code == 4'h0) |=> target_q == 7'h08)
		else $error("shortest reply gap is not eight bit times");

	a_gap_longest: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		s_gap_started ##0 (gap.code == 4'he) |=> target_q == 7'h78)
		else $error("longest reply gap is not fifteen units");

endmodule : reply_gap_timer

/* File: serial_host_model.sv */
/*
 * Serial front end model: raises one reply request, then paces bit-time ticks until the
 * block lets the reply go, counting the ticks it handed over.
 * Assumes it shares the block clock; the block samples its outputs on the rising edge.
 */
module serial_host_model #(
	parameter int PERIOD = 4
) (
	input  wire logic i_ref_clk,
	input  wire logic i_start,
	input  wire logic i_reply_go,
	output logic      o_reply_req,
	output logic      o_bit_tick,
	output logic      o_busy,
	output int        o_ticks
);
	timeunit 1ns;
	timeprecision 1ps;

	int   cnt     = 0;
	logic req_q   = 1'b0;
	logic tick_q  = 1'b0;
	logic busy_q  = 1'b0;
	int   ticks_q = 0;

	// ticks start PERIOD cycles after the request, so none falls in the accept cycle
	always @(negedge i_ref_clk) begin
		req_q  <= i_start && !busy_q;
		tick_q <= busy_q && !i_reply_go && cnt == PERIOD - 1;
		if (i_start && !busy_q) begin
			busy_q  <= 1'b1;
			ticks_q <= 0;
			cnt     <= 0;
		end else if (busy_q) begin
			if (i_reply_go) begin
				busy_q <= 1'b0;
			end else if (cnt == PERIOD - 1) begin
				cnt     <= 0;
				ticks_q <= ticks_q + 1;
			end else begin
				cnt <= cnt + 1;
			end
		end
	end

	assign o_reply_req = req_q;
	assign o_bit_tick  = tick_q;
	assign o_busy      = busy_q;
	assign o_ticks     = ticks_q;

endmodule : serial_host_model

/* File: tb.sv */
/*
 * Self-checking bench for the node setup and pin status block.
 * Assumes the package, the gap carrier, the design modules and the host model are compiled first.
 */
`include "node_cfg_regs.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import node_cfg_pkg::*;

	localparam logic [7:0] VER = 8'h3c; // arbitrary value

	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [6:0]  addr = 7'h00;
	word_t       wdata = 32'h0;
	logic [15:0] pins = 16'h0;
	logic [2:0]  strap = 3'h0;
	logic        start = 1'b0;
	logic        ce = 1'b1;
	word_t       rdata;
	slot_t       node_addr;
	logic        rvalid, req, tick, go, next_addr, next_addr_oe_n, host_busy;
	int          ticks;
	int          n_mismatch = 0;
	int          n_compared = 0;
	logic [3:0]  codes [9] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc, 4'he};

	always #5 clk = ~clk;

	node_cfg_block #(.CHIP_VERSION(VER), .DIE_REVISION(3'h0)) i_node_cfg_block (
		.i_ref_clk(clk),
		.i_srst(srst),
		.i_clk_en(ce),
		.i_reg_wr(wr),
		.i_reg_rd(rd),
		.i_reg_addr(addr),
		.i_reg_wdata(wdata),
		.o_reg_rdata(rdata),
		.o_reg_rvalid(rvalid),
		.i_reply_req(req),
		.i_bit_tick(tick),
		.o_reply_go(go),
		.o_node_addr(node_addr),
		.i_left_stop_pin(pins[0]),
		.i_right_stop_pin(pins[1]),
		.i_encoder_b_pin(pins[2]),
		.i_encoder_a_pin(pins[3]),
		.i_bridge_off_pin(pins[4]),
		.i_encoder_index_pin(pins[5]),
		.i_one_wire_serial(pins[6]),
		.i_csn_pin(strap[2]),
		.i_sck_pin(strap[1]),
		.i_sdi_pin(strap[0]),
		.i_cmp_levels(pins[11:8]),
		.i_conv_fault(pins[15]),
		.i_outside_osc_selected(pins[14]),
		.i_ref_resistor_found(pins[13]),
		.o_next_addr_out(next_addr),
		.o_next_addr_oe_n(next_addr_oe_n)
	);

	serial_host_model #(.PERIOD(4)) i_serial_host_model (
		.i_ref_clk(clk),
		.i_start(start),
		.i_reply_go(go),
		.o_reply_req(req),
		.o_bit_tick(tick),
		.o_busy(host_busy),
		.o_ticks(ticks)
	);

	function automatic word_t stat_exp(input logic pol);
		return {VER, 5'h0, 3'h0, pins[15:13], pol, pins[11:8], 1'b0, pins[6:0]};
	endfunction : stat_exp

	task automatic chk(input string what, input word_t exp, input word_t got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic reg_wr(input logic [6:0] a, input word_t d);
		@(negedge clk);
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [6:0] a, input word_t exp, input string what);
		@(negedge clk);
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		rd = 1'b0;
		chk("rvalid", 32'h1, {31'h0, rvalid});
		chk(what, exp, rdata);
	endtask : reg_rd

	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_of_test

	initial begin
		#200000;
		n_mismatch++;
		end_of_test();
	end

	initial begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		srst = 1'b0;
		reg_rd(`NODE_SETUP_IDX, 32'h0, "node_setup reset");
		reg_rd(`PIN_STATUS_IDX, stat_exp(1'b1), "status reset");
		chk("next_addr_out reset", 32'h1, {31'h0, next_addr});
		// walk a single high level across every input that the status word reports
		for (int i = 0; i < 16; i++) begin
			if (i == 7 || i == 12) continue;
			@(negedge clk);
			pins = 16'h1 << i;
			repeat (3) @(negedge clk);
			reg_rd(`PIN_STATUS_IDX, stat_exp(1'b1), "status pin");
			chk("next_addr_oe_n", {31'h0, i != 6}, {31'h0, next_addr_oe_n});
		end
		@(negedge clk);
		pins = 16'h0040;
		reg_wr(`PIN_STATUS_IDX, 32'hffff_efff);
		reg_rd(`PIN_STATUS_IDX, stat_exp(1'b0), "status after write");
		chk("next_addr_out low", 32'h0, {31'h0, next_addr});
		reg_wr(`PIN_STATUS_IDX, 32'h0000_1000);
		reg_rd(`PIN_STATUS_IDX, stat_exp(1'b1), "status polarity set");
		chk("next_addr_out high", 32'h1, {31'h0, next_addr});
		// base 0xf7 plus the largest strap offset stays at 254
		reg_wr(`NODE_SETUP_IDX, 32'hffff_fef7);
		reg_wr(7'h05, 32'h0);
		reg_rd(`NODE_SETUP_IDX, 32'h0000_0ef7, "node_setup");
		reg_rd(7'h05, 32'h0, "unmapped read");
		// a write while the clock enable is low must not land
		ce = 1'b0;
		reg_wr(`NODE_SETUP_IDX, 32'h0000_0355);
		ce = 1'b1;
		reg_rd(`NODE_SETUP_IDX, 32'h0000_0ef7, "node_setup frozen");
		// write then read in the very next cycle
		@(negedge clk);
		wr = 1'b1;
		addr = `NODE_SETUP_IDX;
		wdata = 32'h0000_0af7;
		@(negedge clk);
		wr = 1'b0;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		chk("node_setup back to back", 32'h0000_0af7, rdata);
		for (int k = 0; k < 8; k++) begin
			@(negedge clk);
			strap = k[2:0];
			repeat (4) @(negedge clk);
			chk("node_addr", {24'h0, 8'hf7 + 8'(k)}, {24'h0, node_addr});
		end
		// one node on the line, so the shortest gap is allowed here
		foreach (codes[j]) begin
			reg_wr(`NODE_SETUP_IDX, {20'h0, codes[j], 8'h01});
			@(negedge clk);
			start <= 1'b1;
			@(negedge clk);
			start <= 1'b0;
			@(negedge clk);
			for (int w = 0; w < 2000 && host_busy; w++) @(negedge clk);
			chk("gap ticks", {28'h0, codes[j] | 4'h1} * 8, ticks);
			chk("reply_go width", 32'h0, {31'h0, go});
		end
		// a second reset brings the polarity bit back to one
		@(negedge clk);
		pins = 16'h0;
		reg_wr(`PIN_STATUS_IDX, 32'h0);
		@(negedge clk);
		srst = 1'b1;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		reg_rd(`PIN_STATUS_IDX, stat_exp(1'b1), "status after reset");
		reg_rd(`NODE_SETUP_IDX, 32'h0, "node_setup after reset");
		chk("next_addr_out after reset", 32'h1, {31'h0, next_addr});
		end_of_test();
	end

endmodule : tb
